// ==== apfso_regs.vh ====
// Shared constants for the audio playback FIFO and serial output block.
`ifndef APFSO_REGS_VH
`define APFSO_REGS_VH
`define APFSO_SAMPLE_BITS   16
`define APFSO_WORD_BITS     32
`define APFSO_FIFO_DEPTH    16
`define APFSO_LEFT_MSB      31
`define APFSO_LEFT_LSB      16
`define APFSO_RIGHT_MSB     15
`define APFSO_RIGHT_LSB     0
`define APFSO_ZERO_SAMPLE   16'h0000
`define APFSO_ZERO_BIT      1'h0
`define APFSO_SET_BIT       1'h1
`define APFSO_MCLK_KHZ      18432
`define APFSO_BLOCK_BYTES   512
`endif

// ==== apfso_fifo.v ====
// Synchronous FIFO with a registered output stage and valid/ready on both sides.
`timescale 1ns/100ps
`include "apfso_regs.vh"
module apfso_fifo #(
  parameter WIDTH = `APFSO_WORD_BITS,
  parameter DEPTH = `APFSO_FIFO_DEPTH
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output wire             inReady,
  output wire             full,
  output reg              outValid_ff,
  output reg  [WIDTH-1:0] outData_ff,
  input  wire             outReady
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_ff;
  reg [AW-1:0]    rdPtr_ff;
  reg [AW:0]      count_ff;

  wire doWrite = inValid & ~full;
  wire doLoad  = (count_ff != {(AW+1){1'h0}}) & (~outValid_ff | outReady);

  assign full    = (count_ff == DEPTH[AW:0]);
  assign inReady = ~full;

  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wrPtr_ff    <= {AW{1'h0}};
      rdPtr_ff    <= {AW{1'h0}};
      count_ff    <= {(AW+1){1'h0}};
      outValid_ff <= 1'h0;
      outData_ff  <= {WIDTH{1'h0}};
    end else begin
      if (doWrite) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'h1) ? {AW{1'h0}} : wrPtr_ff + 1'h1;
      end
      if (doLoad) begin
        outData_ff  <= mem[rdPtr_ff];
        outValid_ff <= 1'h1;
        rdPtr_ff    <= (rdPtr_ff == DEPTH[AW-1:0] - 1'h1) ? {AW{1'h0}} : rdPtr_ff + 1'h1;
      end else if (outReady) begin
        outValid_ff <= 1'h0;
      end
      if (doWrite & ~doLoad) begin
        count_ff <= count_ff + 1'h1;
      end else if (~doWrite & doLoad) begin
        count_ff <= count_ff - 1'h1;
      end
    end
  end
endmodule

// ==== apfso_serial_out.v ====
// Audio playback block: sample FIFO fed by the processor, I2S serial output to the codec.
`timescale 1ns/100ps
`include "apfso_regs.vh"
module apfso_serial_out #(
  parameter SAMPLE_BITS = `APFSO_SAMPLE_BITS,
  parameter FIFO_DEPTH  = `APFSO_FIFO_DEPTH
) (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     audioMclkIn,
  output wire                     codecMclk,
  input  wire                     serialBitClock,
  input  wire                     channelSelectClock,
  output reg                      serialData_ff,
  input  wire                     wrValid,
  input  wire [2*SAMPLE_BITS-1:0] wrData,
  output wire                     wrReady,
  output wire                     fifoFull,
  output reg                      underrun_ff
);
  localparam WB       = 2 * SAMPLE_BITS;
  localparam CW       = $clog2(SAMPLE_BITS + 1);
  localparam ST_WAIT  = 2'h0;
  localparam ST_LEFT  = 2'h1;
  localparam ST_RIGHT = 2'h2;

  reg                   bclkMeta_ff;
  reg                   bclkSync_ff;
  reg                   bclkPrev_ff;
  reg                   lrMeta_ff;
  reg                   lrSync_ff;
  reg                   lrAtFall_ff;
  reg [SAMPLE_BITS-1:0] shift_ff;
  reg [SAMPLE_BITS-1:0] rightHold_ff;
  reg [CW-1:0]          bitCount_ff;
  reg [1:0]             state_ff;
  reg [1:0]             nxt_state;
  reg [CW-1:0]          nxt_bitCount;
  reg [SAMPLE_BITS-1:0] nxt_shift;
  reg [SAMPLE_BITS-1:0] nxt_rightHold;
  reg                   nxt_serialData;
  reg                   nxt_lrAtFall;
  reg                   nxt_underrun;

  wire          fifoValid;
  wire [WB-1:0] fifoData;
  wire          bclkFall;
  wire          lrChange;
  wire          frameStart;
  wire          popWord;
  wire          rightStart;
  wire          bitPending;

  // The master clock goes straight to the codec pin.
  assign codecMclk = audioMclkIn;

  // Both codec clocks pass two flip-flops before any logic looks at them.
  always @(posedge sys_clk) begin
    if (rst) begin
      bclkMeta_ff <= `APFSO_ZERO_BIT;
      bclkSync_ff <= `APFSO_ZERO_BIT;
      bclkPrev_ff <= `APFSO_ZERO_BIT;
      lrMeta_ff   <= `APFSO_ZERO_BIT;
      lrSync_ff   <= `APFSO_ZERO_BIT;
    end else begin
      bclkMeta_ff <= serialBitClock;
      bclkSync_ff <= bclkMeta_ff;
      bclkPrev_ff <= bclkSync_ff;
      lrMeta_ff   <= channelSelectClock;
      lrSync_ff   <= lrMeta_ff;
    end
  end

  // Edges are found from the codec clocks themselves, so no rate is assumed.
  assign bclkFall   = bclkPrev_ff & ~bclkSync_ff;
  assign lrChange   = bclkFall & (lrSync_ff != lrAtFall_ff);
  assign frameStart = lrChange & ~lrSync_ff;
  assign popWord    = frameStart & fifoValid;
  assign rightStart = lrChange & lrSync_ff & (state_ff == ST_LEFT);
  assign bitPending = (bitCount_ff < SAMPLE_BITS[CW-1:0]);

  // The FIFO carries whole stereo words from the write port to the transmitter.
  apfso_fifo #(
    .WIDTH (WB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk         (sys_clk),
    .rst         (rst),
    .inValid     (wrValid),
    .inData      (wrData),
    .inReady     (wrReady),
    .full        (fifoFull),
    .outValid_ff (fifoValid),
    .outData_ff  (fifoData),
    .outReady    (frameStart)
  );

  // Slot tracking: nothing is sent before the first left slot has begun.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT: begin
        if (frameStart) begin
          nxt_state = ST_LEFT;
        end
      end
      ST_LEFT: begin
        if (rightStart) begin
          nxt_state = ST_RIGHT;
        end
      end
      ST_RIGHT: begin
        if (frameStart) begin
          nxt_state = ST_LEFT;
        end
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  // Data change on the bit clock's fall; the MSB follows one bit after the channel edge.
  always @* begin
    nxt_lrAtFall   = lrAtFall_ff;
    nxt_serialData = serialData_ff;
    nxt_shift      = shift_ff;
    nxt_rightHold  = rightHold_ff;
    nxt_bitCount   = bitCount_ff;
    nxt_underrun   = frameStart & ~fifoValid;
    if (bclkFall) begin
      nxt_lrAtFall = lrSync_ff;
      if (bitPending) begin
        nxt_serialData = shift_ff[SAMPLE_BITS-1];
      end else begin
        nxt_serialData = `APFSO_ZERO_BIT;
      end
      if (frameStart) begin
        nxt_bitCount = {CW{`APFSO_ZERO_BIT}};
        if (popWord) begin
          nxt_shift     = fifoData[`APFSO_LEFT_MSB:`APFSO_LEFT_LSB];
          nxt_rightHold = fifoData[`APFSO_RIGHT_MSB:`APFSO_RIGHT_LSB];
        end else begin
          nxt_shift     = `APFSO_ZERO_SAMPLE;
          nxt_rightHold = `APFSO_ZERO_SAMPLE;
        end
      end else if (rightStart) begin
        nxt_bitCount = {CW{`APFSO_ZERO_BIT}};
        nxt_shift    = rightHold_ff;
      end else begin
        nxt_shift = {shift_ff[SAMPLE_BITS-2:0], `APFSO_ZERO_BIT};
        if (bitPending) begin
          nxt_bitCount = bitCount_ff + 1'h1;
        end
      end
    end
  end

  // Slot state register.
  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Channel level seen at the last bit clock fall.
  always @(posedge sys_clk) begin
    if (rst) begin
      lrAtFall_ff <= `APFSO_ZERO_BIT;
    end else begin
      lrAtFall_ff <= nxt_lrAtFall;
    end
  end

  // Sample shifter and the held right half.
  always @(posedge sys_clk) begin
    if (rst) begin
      shift_ff     <= `APFSO_ZERO_SAMPLE;
      rightHold_ff <= `APFSO_ZERO_SAMPLE;
    end else begin
      shift_ff     <= nxt_shift;
      rightHold_ff <= nxt_rightHold;
    end
  end

  // Bits sent since the last load; it starts saturated so reset sends zeros.
  always @(posedge sys_clk) begin
    if (rst) begin
      bitCount_ff <= SAMPLE_BITS[CW-1:0];
    end else begin
      bitCount_ff <= nxt_bitCount;
    end
  end

  // Serial data register towards the codec.
  always @(posedge sys_clk) begin
    if (rst) begin
      serialData_ff <= `APFSO_ZERO_BIT;
    end else begin
      serialData_ff <= nxt_serialData;
    end
  end

  // Underrun pulse, one cycle per frame started on an empty FIFO.
  always @(posedge sys_clk) begin
    if (rst) begin
      underrun_ff <= `APFSO_ZERO_BIT;
    end else begin
      underrun_ff <= nxt_underrun;
    end
  end
endmodule

// ==== apfso_serial_out_checker.sv ====
// Port checks for the audio playback block.
`timescale 1ns/100ps
module apfso_serial_out_checker (
  input wire sys_clk,
  input wire rst,
  input wire audioMclkIn,
  input wire codecMclk,
  input wire serialBitClock,
  input wire serialData_ff,
  input wire wrValid,
  input wire wrReady,
  input wire fifoFull,
  input wire underrun_ff
);
  reg       bcPrev;
  reg [3:0] age;
  always @(posedge sys_clk) begin
    bcPrev <= serialBitClock;
    age    <= (rst || (bcPrev && !serialBitClock)) ? 4'h0 : age + {3'h0, age != 4'hF};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_mclk_fwd: assert property (codecMclk == audioMclkIn) else $error("mclk");
  a_data_fall: assert property ($changed(serialData_ff) |-> age inside {[1:7]})
    else $error("data off clock");
  a_ready_full: assert property (wrReady == !fifoFull) else $error("ready");
  a_full_cause: assert property ($rose(fifoFull) |-> $past(wrValid) || $past(wrValid, 2))
    else $error("full");
  a_full_pop: assert property ($fell(fifoFull) |-> age < 4'h8) else $error("pop");
  a_under_once: assert property (underrun_ff |=> !underrun_ff) else $error("underrun");
  a_under_zero: assert property (underrun_ff |-> (!serialData_ff) [*8]) else $error("zeros");
endmodule

// ==== apfso_codec_model.sv ====
// Codec model that masters both link clocks and captures frames.
`timescale 1ns/100ps
module apfso_codec_model (
  input  wire       run,
  input  wire [5:0] slotBits,
  input  wire       serialData_ff,
  output reg        serialBitClock,
  output reg        channelSelectClock
);
  reg     [31:0] got [0:31];
  reg     [31:0] sh;
  integer        nGot = 0, k = 0;
  initial begin
    {serialBitClock, channelSelectClock} = 2'h1; // Clocks stand still until run.
    wait (run) #1.3;
    forever begin
      #24 serialBitClock = 1'b1;
      if (k > 0 && k < 17) sh = {sh[30:0], serialData_ff}; // One-bit delay, MSB first.
      #24 serialBitClock = 1'b0;
      k = k + 1;
      if (k == slotBits) begin // Channel flips on a fall.
        k = 0;
        got[nGot] = sh;
        nGot = nGot + channelSelectClock;
        channelSelectClock = !channelSelectClock;
      end
    end
  end
endmodule

// ==== apfso_tb.sv ====
// Self-checking bench for the audio playback block.
`timescale 1ns/100ps
module testbench;
  reg         sys_clk = 0, rst = 1, audioMclkIn = 0, wrValid = 0, run = 0;
  reg  [31:0] wrData = 0;
  reg  [5:0]  slotBits = 6'h14;
  wire        codecMclk, serialBitClock, channelSelectClock, serialData_ff, wrReady, fifoFull;
  wire        underrun_ff;
  integer     mismatches = 0, n_tests = 0, cyc = 0, i;
  integer     nUnder = 0;
  always #2 sys_clk = !sys_clk;
  always #27.1 audioMclkIn = !audioMclkIn;
  apfso_serial_out u_dut (.*);
  apfso_codec_model u_codec (.*);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict;
    end
  end
  always @(negedge sys_clk) begin
    if (underrun_ff === 1'h1) nUnder++;
  end
  task check(input string name, input [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) $display("Error %s expected %h seen %h", name, exp, seen);
    mismatches += (seen !== exp);
  endtask
  task wr(input [31:0] d);
    @(negedge sys_clk) {wrValid, wrData} = {1'h1, d};
    @(negedge sys_clk) wrValid = 0;
  endtask
  task test_reset;
    @(negedge sys_clk);
    check("reset", {serialData_ff, wrReady, fifoFull, underrun_ff}, 4'h4);
    $display("test_reset done");
  endtask
  task test_fill_drain;
    for (i = 0; i < 17; i++) wr(32'hA5C30000 + i);
    @(negedge sys_clk) check("full", {wrReady, fifoFull}, 32'h1);
    wr(32'hFFFFFFFF);
    run = 1;
    wait (u_codec.nGot > 19);
    for (i = 0; i < 17; i++) check("frame", u_codec.got[i + 1], 32'hA5C30000 + i);
    check("refused", u_codec.got[18], 32'h0);
    check("underruns", nUnder, 32'h2);
    $display("test_fill_drain done");
  endtask
  task test_underrun_resume;
    slotBits = 6'h20;
    repeat (20) @(negedge sys_clk);
    wr(32'h600DCAFE);
    wait (u_codec.nGot > 21);
    check("resumed", u_codec.got[21], 32'h600DCAFE);
    check("empty frame", u_codec.got[20], 32'h0);
    check("underruns", nUnder, 32'h3);
    $display("test_underrun_resume done");
  endtask
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 0;
    test_reset;
    test_fill_drain;
    test_underrun_resume;
    print_verdict;
  end
endmodule
bind apfso_serial_out apfso_serial_out_checker u_chk (.*);
